// ===== include/i2cm_map.svh
// register offsets, field positions and the baud reset value of the two-wire master
`ifndef I2CM_MAP_SVH
`define I2CM_MAP_SVH
`define I2CM_ADDR_W        4
`define I2CM_OFF_CTRL      4'h0
`define I2CM_OFF_CMD       4'h1
`define I2CM_OFF_BUF       4'h2
`define I2CM_OFF_BAUD      4'h3
`define I2CM_OFF_STATUS    4'h4
`define I2CM_OFF_IRQ_STAT  4'h5
`define I2CM_OFF_IRQ_CLR   4'h6
`define I2CM_OFF_IRQ_EN    4'h7
`define I2CM_OFF_SW_PINS   4'h8
`define I2CM_CTRL_EN_BIT   4
`define I2CM_CMD_START     0
`define I2CM_CMD_RSTART    1
`define I2CM_CMD_STOP      2
`define I2CM_CMD_RCV       3
`define I2CM_CMD_ACKDT     4
`define I2CM_MODE_HW       4'h8
`define I2CM_MODE_FW       4'hb
`define I2CM_BAUD_RST      8'h09
`define I2CM_IRQ_SPIF      0
`define I2CM_IRQ_WRITE_COLLISION_FLAG      1
`define I2CM_IRQ_ARB       2
`endif

// ===== include/i2cm_pkg.sv
// types shared by the two-wire master
package i2cm_pkg;
    typedef enum logic [3:0] {
        I2CM_IDLE   = 4'b0000,
        I2CM_START  = 4'b0001,
        I2CM_RSTART = 4'b0010,
        I2CM_BIT_LO = 4'b0011,
        I2CM_BIT_HI = 4'b0100,
        I2CM_ACK_LO = 4'b0101,
        I2CM_ACK_HI = 4'b0110,
        I2CM_STOP   = 4'b0111,
        I2CM_HOLD   = 4'b1000
    } i2cm_state_e;
endpackage

// ===== hw/i2cm_cond_det.sv
// start and stop condition detector on synchronised bus lines
module i2cm_cond_det
(
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic enable,
    input  wire logic scl_pin,
    input  wire logic sda_pin,
    output logic      start_seen,
    output logic      stop_seen,
    output logic      start_pulse,
    output logic      stop_pulse
);
    // ========================================
    // synchronisers and edge detection
    logic [1:0] scl_sync_q;
    logic [1:0] sda_sync_q;
    logic       sda_prev_q;
    logic       scl_prev_q;
    logic       s_d;
    logic       p_d;
    logic       sp_d;
    logic       pp_d;

    always_comb
    begin
        sp_d = scl_sync_q[1] && scl_prev_q && sda_prev_q && !sda_sync_q[1];
        pp_d = scl_sync_q[1] && scl_prev_q && !sda_prev_q && sda_sync_q[1];
        s_d  = start_seen;
        p_d  = stop_seen;
        if (!enable)
        begin
            s_d = 1'b0;
            p_d = 1'b0;
        end
        else if (sp_d)
        begin
            s_d = 1'b1;
            p_d = 1'b0;
        end
        else if (pp_d)
        begin
            s_d = 1'b0;
            p_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            scl_sync_q  <= 2'h3;
            sda_sync_q  <= 2'h3;
            scl_prev_q  <= 1'b1;
            sda_prev_q  <= 1'b1;
            start_seen  <= 1'b0;
            stop_seen   <= 1'b0;
            start_pulse <= 1'b0;
            stop_pulse  <= 1'b0;
        end
        else
        begin
            scl_sync_q  <= {scl_sync_q[0], scl_pin};
            sda_sync_q  <= {sda_sync_q[0], sda_pin};
            scl_prev_q  <= scl_sync_q[1];
            sda_prev_q  <= sda_sync_q[1];
            start_seen  <= s_d;
            stop_seen   <= p_d;
            start_pulse <= sp_d && enable;
            stop_pulse  <= pp_d && enable;
        end
    end
endmodule

// ===== hw/i2cm_master.sv
// two-wire serial master with register port, baud generator and start/stop detector
//
// Decided for this implementation: strobed register access and the register addresses.
module i2cm_master
    import i2cm_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    output logic            irq,
    input  wire logic       scl_i,
    output logic            scl_o,
    output logic            scl_oe,
    input  wire logic       sda_i,
    output logic            sda_o,
    output logic            sda_oe
);
    `include "i2cm_map.svh"

    // ========================================
    // registers
    logic [7:0]  ctrl_q, ctrl_d;
    logic [4:0]  cmd_q, cmd_d;
    logic [7:0]  buf_q, buf_d;
    logic [7:0]  baud_q, baud_d;
    logic [2:0]  ista_q, ista_d;
    logic [2:0]  ien_q, ien_d;
    logic [1:0]  swp_q, swp_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        irq_q;
    logic        ack_in_q, ack_in_d;
    logic [1:0]  scl_s_q, sda_s_q;
    i2cm_state_e st_q, st_d;
    logic [7:0]  cnt_q, cnt_d;
    logic [3:0]  bit_q, bit_d;
    logic        phase_q, phase_d;
    logic        scl_lo_q, scl_lo_d;
    logic        sda_lo_q, sda_lo_d;
    logic        rx_q, rx_d;
    logic        start_seen, stop_seen, sp_pulse, pp_pulse;
    logic        en, hw_mode, fw_mode;
    logic        tick, ev_spif, ev_write_collision_flag, ev_arb, busy_start;

    function automatic logic is_wr(input logic [3:0] a);
        is_wr = reg_wr && (reg_addr == a);
    endfunction

    assign en      = ctrl_q[`I2CM_CTRL_EN_BIT];
    assign hw_mode = en && (ctrl_q[3:0] == `I2CM_MODE_HW);
    assign fw_mode = en && (ctrl_q[3:0] == `I2CM_MODE_FW);
    assign tick    = (cnt_q == 8'h00);
    assign busy_start = (st_q == I2CM_START) || (st_q == I2CM_RSTART);

    i2cm_cond_det u_det
    (
        .ref_clk     (ref_clk),
        .rst_n       (rst_n),
        .enable      (en),
        .scl_pin     (scl_i),
        .sda_pin     (sda_i),
        .start_seen  (start_seen),
        .stop_seen   (stop_seen),
        .start_pulse (sp_pulse),
        .stop_pulse  (pp_pulse)
    );

    // ========================================
    // bus engine
    always_comb
    begin
        st_d     = st_q;
        cnt_d    = tick ? baud_q : cnt_q - 8'h01;
        bit_d    = bit_q;
        phase_d  = phase_q;
        scl_lo_d = scl_lo_q;
        sda_lo_d = sda_lo_q;
        rx_d     = rx_q;
        buf_d    = buf_q;
        ack_in_d = ack_in_q;
        cmd_d    = cmd_q;
        ev_spif  = 1'b0;
        ev_arb   = 1'b0;
        ev_write_collision_flag  = 1'b0;
        if (is_wr(`I2CM_OFF_CMD))
            cmd_d = reg_wdata[4:0];
        if (is_wr(`I2CM_OFF_BUF))
        begin
            if (busy_start || st_q != I2CM_IDLE && st_q != I2CM_HOLD)
                ev_write_collision_flag = 1'b1;
            else
                buf_d = reg_wdata;
        end
        if (!hw_mode)
        begin
            st_d     = I2CM_IDLE;
            scl_lo_d = 1'b0;
            sda_lo_d = 1'b0;
            cmd_d    = 5'h00;
            // firmware mode: pins follow software, detector alone is active
            ev_spif  = fw_mode && (sp_pulse || pp_pulse);
        end
        else
        begin
            case (st_q)
                I2CM_IDLE, I2CM_HOLD:
                begin
                    cnt_d = baud_q;
                    phase_d = 1'b0;
                    if (cmd_q[`I2CM_CMD_START] && st_q == I2CM_IDLE)
                        st_d = I2CM_START;
                    else if (cmd_q[`I2CM_CMD_RSTART] && st_q == I2CM_HOLD)
                        st_d = I2CM_RSTART;
                    else if (cmd_q[`I2CM_CMD_STOP] && st_q == I2CM_HOLD)
                        st_d = I2CM_STOP;
                    else if (st_q == I2CM_HOLD && (is_wr(`I2CM_OFF_BUF) && !ev_write_collision_flag
                             || cmd_q[`I2CM_CMD_RCV]))
                    begin
                        // address and direction bit come from the buffer byte
                        rx_d  = cmd_q[`I2CM_CMD_RCV];
                        cmd_d[`I2CM_CMD_RCV] = 1'b0;
                        bit_d = 4'h0;
                        st_d  = I2CM_BIT_LO;
                    end
                end
                I2CM_START, I2CM_RSTART:
                if (scl_lo_q && !phase_q)
                begin
                    // repeated start: free data while clock is low, then free clock
                    sda_lo_d = 1'b0;
                    scl_lo_d = !tick;
                end
                else if (tick)
                begin
                    // start: sda low while scl high, then scl low
                    if (!phase_q)
                    begin
                        if (!sda_lo_q && !sda_s_q[1] && st_q == I2CM_START)
                        begin
                            cnt_d  = baud_q;
                            ev_arb = 1'b1;
                            st_d   = I2CM_IDLE;
                            cmd_d  = 5'h00;
                        end
                        else if (!sda_lo_q && scl_s_q[1])
                            sda_lo_d = 1'b1;
                        else if (sda_lo_q)
                            phase_d = 1'b1;
                    end
                    else
                    begin
                        scl_lo_d = 1'b1;
                        phase_d  = 1'b0;
                        st_d     = I2CM_HOLD;
                        cmd_d[`I2CM_CMD_START]  = 1'b0;
                        cmd_d[`I2CM_CMD_RSTART] = 1'b0;
                        ev_spif  = 1'b1;
                    end
                end
                I2CM_BIT_LO:
                begin
                    // data moves only while the clock is held low
                    sda_lo_d = !rx_q && !buf_q[7];
                    scl_lo_d = !tick;
                    if (tick)
                        st_d = I2CM_BIT_HI;
                end
                I2CM_BIT_HI:
                if (tick)
                begin
                    scl_lo_d = 1'b1;
                    buf_d    = {buf_q[6:0], sda_s_q[1]};
                    bit_d    = bit_q + 4'h1;
                    if (bit_q == 4'h7)
                        st_d = I2CM_ACK_LO;
                    else
                        st_d = I2CM_BIT_LO;
                end
                I2CM_ACK_LO:
                begin
                    sda_lo_d = rx_q && !cmd_q[`I2CM_CMD_ACKDT];
                    scl_lo_d = !tick;
                    if (tick)
                        st_d = I2CM_ACK_HI; // tx releases sda
                end
                I2CM_ACK_HI:
                if (tick)
                begin
                    scl_lo_d = 1'b1;
                    ack_in_d = sda_s_q[1];
                    st_d     = I2CM_HOLD;
                    ev_spif  = 1'b1;
                end
                I2CM_STOP:
                if (!phase_q)
                begin
                    // pull data while the clock is low so no false start appears
                    sda_lo_d = 1'b1;
                    scl_lo_d = !tick;
                    phase_d  = tick;
                end
                else if (tick)
                begin
                    sda_lo_d = 1'b0;
                    phase_d  = 1'b0;
                    st_d     = I2CM_IDLE;
                    cmd_d[`I2CM_CMD_STOP] = 1'b0;
                    ev_spif  = 1'b1;
                end
                default:
                    st_d = I2CM_IDLE;
            endcase
        end
    end

    // ========================================
    // register port and interrupts
    always_comb
    begin
        ctrl_d  = ctrl_q;
        baud_d  = baud_q;
        ien_d   = ien_q;
        swp_d   = swp_q;
        ista_d  = ista_q;
        rdata_d = 8'h00;
        if (is_wr(`I2CM_OFF_CTRL))
            ctrl_d = reg_wdata;
        if (is_wr(`I2CM_OFF_BAUD))
            baud_d = reg_wdata;
        if (is_wr(`I2CM_OFF_IRQ_EN))
            ien_d = reg_wdata[2:0];
        if (is_wr(`I2CM_OFF_SW_PINS))
            swp_d = reg_wdata[1:0];
        if (is_wr(`I2CM_OFF_IRQ_CLR))
            ista_d = ista_q & ~reg_wdata[2:0];
        // set wins over a same-cycle clear
        ista_d = ista_d | {ev_arb, ev_write_collision_flag, ev_spif};
        if (reg_rd)
        begin
            if (reg_addr == `I2CM_OFF_CTRL)
                rdata_d = ctrl_q;
            else if (reg_addr == `I2CM_OFF_CMD)
                rdata_d = {3'h0, cmd_q};
            else if (reg_addr == `I2CM_OFF_BUF)
                rdata_d = buf_q;
            else if (reg_addr == `I2CM_OFF_BAUD)
                rdata_d = baud_q;
            else if (reg_addr == `I2CM_OFF_STATUS)
                rdata_d = {2'h0, ack_in_q, (st_q != I2CM_IDLE), start_seen, stop_seen,
                           sda_s_q[1], scl_s_q[1]};
            else if (reg_addr == `I2CM_OFF_IRQ_STAT)
                rdata_d = {5'h00, ista_q};
            else if (reg_addr == `I2CM_OFF_IRQ_EN)
                rdata_d = {5'h00, ien_q};
            else if (reg_addr == `I2CM_OFF_SW_PINS)
                rdata_d = {6'h00, swp_q};
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q   <= 8'h00;
            cmd_q    <= 5'h00;
            buf_q    <= 8'h00;
            baud_q   <= `I2CM_BAUD_RST;
            ista_q   <= 3'h0;
            ien_q    <= 3'h0;
            swp_q    <= 2'h3;
            rdata_q  <= 8'h00;
            irq_q    <= 1'b0;
            ack_in_q <= 1'b1;
            scl_s_q  <= 2'h3;
            sda_s_q  <= 2'h3;
            st_q     <= I2CM_IDLE;
            cnt_q    <= `I2CM_BAUD_RST;
            bit_q    <= 4'h0;
            phase_q  <= 1'b0;
            scl_lo_q <= 1'b0;
            sda_lo_q <= 1'b0;
            rx_q     <= 1'b0;
            scl_oe   <= 1'b0;
            sda_oe   <= 1'b0;
        end
        else
        begin
            ctrl_q   <= ctrl_d;
            cmd_q    <= cmd_d;
            buf_q    <= buf_d;
            baud_q   <= baud_d;
            ista_q   <= ista_d;
            ien_q    <= ien_d;
            swp_q    <= swp_d;
            rdata_q  <= rdata_d;
            irq_q    <= |(ista_d & ien_d);
            ack_in_q <= ack_in_d;
            scl_s_q  <= {scl_s_q[0], scl_i};
            sda_s_q  <= {sda_s_q[0], sda_i};
            st_q     <= st_d;
            cnt_q    <= cnt_d;
            bit_q    <= bit_d;
            phase_q  <= phase_d;
            scl_lo_q <= scl_lo_d;
            sda_lo_q <= sda_lo_d;
            rx_q     <= rx_d;
            // open drain: enable only to pull low; firmware mode uses software pins
            scl_oe   <= hw_mode ? scl_lo_d : (fw_mode && !swp_d[0]);
            sda_oe   <= hw_mode ? sda_lo_d : (fw_mode && !swp_d[1]);
        end
    end

    assign scl_o     = 1'b0;
    assign sda_o     = 1'b0;
    assign reg_rdata = rdata_q;
    assign irq       = irq_q;
endmodule

// ===== verif/i2cm_monitor.sv
// port checker for the two-wire master
`include "i2cm_map.svh"
module i2cm_monitor
(
    input wire logic       ref_clk,
    input wire logic       rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic       irq,
    input wire logic       scl_i,
    input wire logic       scl_o,
    input wire logic       scl_oe,
    input wire logic       sda_i,
    input wire logic       sda_o,
    input wire logic       sda_oe
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    // ==========================================
    // shadow of control and irq enable
    logic [4:0] ctrl_q;
    logic [4:0] ctrl_d;
    logic [2:0] ien_q;
    logic [2:0] ien_d;
    always_comb
    begin
        ctrl_d = ctrl_q;
        ien_d  = ien_q;
        if (reg_wr && reg_addr == `I2CM_OFF_CTRL)
            ctrl_d = reg_wdata[4:0];
        if (reg_wr && reg_addr == `I2CM_OFF_IRQ_EN)
            ien_d = reg_wdata[2:0];
    end
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= 5'h00;
            ien_q  <= 3'h0;
        end
        else
        begin
            ctrl_q <= ctrl_d;
            ien_q  <= ien_d;
        end
    end
    wire en    = ctrl_q[4];
    wire hw    = ctrl_q == 5'h18;
    wire fw    = ctrl_q == 5'h1b;
    wire st_rd = reg_rd && reg_addr == `I2CM_OFF_STATUS && !en;
    // ==========================================
    // assertions
    a_open_drain: assert property (scl_o == 1'b0 && sda_o == 1'b0)
        else $error("bus output driven high");
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_disabled_quiet: assert property (!en [*3] |-> !scl_oe && !sda_oe)
        else $error("lines pulled while disabled");
    a_fw_pin: assert property (fw && reg_wr && reg_addr == `I2CM_OFF_SW_PINS
        && !reg_wdata[1] |-> ##[1:3] sda_oe) else $error("firmware pin ignored");
    a_start_hold: assert property (hw && $rose(sda_oe) && !scl_oe
        |-> ##1 (sda_oe && !scl_oe) [*8]) else $error("start hold too short");
    a_scl_low: assert property (hw && $rose(scl_oe) |-> scl_oe [*8])
        else $error("clock low phase too short");
    a_scl_high: assert property (hw && $fell(scl_oe) |-> !scl_oe [*8])
        else $error("clock high phase too short");
    a_irq_masked: assert property (ien_q == 3'h0 && $past(ien_q) == 3'h0 |-> !irq)
        else $error("irq with all sources masked");
    a_status_clear: assert property ($past(st_rd) && !$past(en, 2)
        |-> reg_rdata[3:2] == 2'b00) else $error("start or stop seen while disabled");
    c_start: cover property (hw && $rose(sda_oe) && !scl_oe);
    c_irq: cover property ($rose(irq));
    c_fw: cover property (fw && sda_oe);
endmodule
bind i2cm_master i2cm_monitor u_mon
(
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe)
);

// ===== verif/i2cm_target_model.sv
// behavioural target device on the shared two-wire bus
module i2cm_target_model
#(
    parameter logic [6:0] TGT_ADDR = 7'h2a,
    parameter logic [7:0] TX_BYTE  = 8'ha5
)
(
    input  wire logic       scl,
    input  wire logic       sda,
    output logic            sda_pull,
    output logic      [7:0] got,
    output logic            mack
);
    timeunit 1ns;
    timeprecision 1ps;
    int   cnt   = 9;
    logic first = 1'b0;
    logic rd    = 1'b0;
    logic dir   = 1'b0;
    logic hit   = 1'b0;
    initial sda_pull = 1'b0;
    // ==========================================
    // start and stop seen on the wire
    always @(negedge sda)
        if (scl)
        begin
            cnt = 0;
            first = 1'b1;
            rd = 1'b0;
        end
    always @(posedge sda)
        if (scl)
            cnt = 9;
    // ==========================================
    // bits sampled on rising clock
    always @(posedge scl)
        if (cnt < 8)
        begin
            got = {got[6:0], sda};
            cnt++;
        end
        else if (cnt == 8)
        begin
            if (rd)
                mack = sda;
            rd = first ? dir && hit : rd && !sda;
            first = 1'b0;
            cnt = 0;
        end
    // ==========================================
    // data and acknowledge changed on falling clock
    always @(negedge scl)
        if (cnt == 8)
        begin
            if (first)
            begin
                hit = got[7:1] == TGT_ADDR;
                dir = got[0];
            end
            sda_pull = !rd && hit;
        end
        else if (cnt < 8)
            sda_pull = rd && !TX_BYTE[7 - cnt];
endmodule

// ===== verif/testbench.sv
// self-checking bench for the two-wire master
`include "i2cm_map.svh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic       ref_clk    = 1'b0;
    logic       rst_n      = 1'b0;
    logic [3:0] reg_addr   = 4'h0;
    logic [7:0] reg_wdata  = 8'h00;
    logic       reg_wr     = 1'b0;
    logic       reg_rd     = 1'b0;
    logic       other_pull = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] got;
    logic       irq;
    logic       scl_o;
    logic       scl_oe;
    logic       sda_o;
    logic       sda_oe;
    logic       tgt_pull;
    logic       mack;
    int         failures   = 0;
    int         tests_run  = 0;
    // open drain wire levels, pulled up when released
    wire scl = scl_oe ? scl_o : 1'b1;
    wire sda = (sda_oe ? sda_o : 1'b1) && !tgt_pull && !other_pull;
    always #5 ref_clk = !ref_clk;
    i2cm_master u_dut
    (
        .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
        .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe)
    );
    i2cm_target_model u_tgt
    (
        .scl(scl), .sda(sda), .sda_pull(tgt_pull), .got(got), .mack(mack)
    );
    // ==========================================
    // access and compare tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge ref_clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input string what, input logic [3:0] a, input logic [7:0] m,
                      input logic [7:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge ref_clk);
        reg_rd   <= 1'b0;
        #1;
        check(what, reg_rdata & m, e);
    endtask
    task automatic irq_is(input logic e);
        @(posedge ref_clk);
        #1;
        check("irq", {7'h00, irq}, {7'h00, e});
    endtask
    // bounded wait: a lost event must not hang the run
    task automatic wait_irq();
        int n = 0;
        do
        begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        while (irq !== 1'b1 && n < 3000);
        check("irq", {7'h00, irq}, 8'h01);
    endtask
    task automatic op(input logic [3:0] a, input logic [7:0] d);
        wr(a, d);
        wait_irq();
        wr(`I2CM_OFF_IRQ_CLR, 8'h01);
        #1;
    endtask
    task automatic print_verdict();
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #900000;
        failures++;
        print_verdict();
    end
    // ==========================================
    // scenarios
    initial
    begin
        repeat (4) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd("baud", `I2CM_OFF_BAUD, 8'hff, `I2CM_BAUD_RST);
        rd("irq stat", `I2CM_OFF_IRQ_STAT, 8'hff, 8'h00);
        rd("status", `I2CM_OFF_STATUS, 8'hff, 8'h23);
        rd("unmapped", 4'hf, 8'hff, 8'h00);
        wr(`I2CM_OFF_IRQ_EN, 8'h07);
        wr(`I2CM_OFF_CTRL, 8'h18);
        wr(`I2CM_OFF_CMD, 8'h01);
        wr(`I2CM_OFF_BUF, 8'h54);
        rd("collision", `I2CM_OFF_IRQ_STAT, 8'h07, 8'h02);
        rd("dropped", `I2CM_OFF_BUF, 8'hff, 8'h00);
        wr(`I2CM_OFF_IRQ_CLR, 8'h02);
        wait_irq();
        rd("start done", `I2CM_OFF_IRQ_STAT, 8'h07, 8'h01);
        rd("start bit", `I2CM_OFF_CMD, 8'h0f, 8'h00);
        wr(`I2CM_OFF_IRQ_CLR, 8'hff);
        irq_is(1'b0);
        op(`I2CM_OFF_BUF, 8'h54);
        check("addr byte", got, 8'h54);
        rd("ack", `I2CM_OFF_STATUS, 8'h20, 8'h00);
        op(`I2CM_OFF_BUF, 8'h3c);
        check("data byte", got, 8'h3c);
        op(`I2CM_OFF_CMD, 8'h04);
        rd("stop", `I2CM_OFF_STATUS, 8'h17, 8'h07);
        // wrong target, then repeated start and a read
        op(`I2CM_OFF_CMD, 8'h01);
        op(`I2CM_OFF_BUF, 8'h22);
        rd("nack", `I2CM_OFF_STATUS, 8'h20, 8'h20);
        op(`I2CM_OFF_CMD, 8'h02);
        check("bus kept", {7'h00, sda_oe}, 8'h01);
        op(`I2CM_OFF_BUF, 8'h55);
        check("read addr", got, 8'h55);
        op(`I2CM_OFF_CMD, 8'h08);
        rd("rx byte", `I2CM_OFF_BUF, 8'hff, 8'ha5);
        check("master ack", {7'h00, mack}, 8'h00);
        op(`I2CM_OFF_CMD, 8'h18);
        rd("rx last", `I2CM_OFF_BUF, 8'hff, 8'ha5);
        check("master nack", {7'h00, mack}, 8'h01);
        op(`I2CM_OFF_CMD, 8'h04);
        wr(`I2CM_OFF_CTRL, 8'h08);
        rd("flags off", `I2CM_OFF_STATUS, 8'h0c, 8'h00);
        // firmware mode: software makes start and stop
        wr(`I2CM_OFF_CTRL, 8'h1b);
        wr(`I2CM_OFF_SW_PINS, 8'h01);
        wait_irq();
        rd("fw start", `I2CM_OFF_STATUS, 8'h08, 8'h08);
        wr(`I2CM_OFF_IRQ_EN, 8'h00);
        irq_is(1'b0);
        wr(`I2CM_OFF_IRQ_EN, 8'h07);
        irq_is(1'b1);
        wr(`I2CM_OFF_IRQ_CLR, 8'hff);
        wr(`I2CM_OFF_SW_PINS, 8'h03);
        wait_irq();
        rd("fw stop", `I2CM_OFF_STATUS, 8'h04, 8'h04);
        wr(`I2CM_OFF_IRQ_CLR, 8'hff);
        // another party holds data low as start begins
        wr(`I2CM_OFF_CTRL, 8'h18);
        other_pull <= 1'b1;
        wr(`I2CM_OFF_CMD, 8'h01);
        wait_irq();
        rd("arb lost", `I2CM_OFF_IRQ_STAT, 8'h04, 8'h04);
        check("released", {6'h00, scl_oe, sda_oe}, 8'h00);
        other_pull <= 1'b0;
        print_verdict();
    end
endmodule
